// ### common/ctsr_pkg.sv
package ctsr_pkg;

    // Clock and timing.
    localparam int CLK_PERIOD_NS = 50;
    localparam int DEB_TIME_NS = 10_000;
    localparam int DEB_CYC = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_CW = 16;

    // Geometry.
    localparam int SR_DEPTH = 64;
    localparam int LEN_W = 7;
    localparam int FIFO_W = 1;
    localparam int FIFO_D = 8;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SHIFT_LEN = 8'h04;
    localparam logic [7:0] OFS_PULSE_LEN = 8'h08;
    localparam logic [7:0] OFS_OSC_PERIOD = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_SHIFT_CNT = 8'h14;

    // Reset values.
    localparam logic [LEN_W-1:0] RST_SHIFT_LEN = 7'h08;
    localparam logic [31:0] RST_PULSE_LEN = 32'h0000_0064;
    localparam logic [31:0] RST_OSC_PERIOD = 32'h0000_4E20;

    // Field positions.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_OSC_BIT = 1;
    localparam int CTRL_SLOW_BIT = 2;
    localparam int CTRL_LATCH_BIT = 3;
    localparam int ST_OUT_BIT = 0;
    localparam int ST_FULL_BIT = 1;
    localparam int ST_EMPTY_BIT = 2;
    localparam int ST_PEND_BIT = 3;

    // Bus answers.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic latch_mode;
        logic slow;
        logic osc_sel;
        logic enable;
    } ctsr_ctrl_t;

    typedef enum logic [2:0] {
        OS_IDLE = 3'b001,
        OS_PULSE = 3'b010,
        OS_LATCH = 3'b100
    } ctsr_ostate_t;

endpackage

// ### src/ctsr_top.sv
// Function
// - Each captured inspection result enters the memory and all stored results advance one place per shift pulse, unless the output buffer is full.
// - The output energizes when a stored result has been advanced through the programmed number of places.
// - A selectable slow response filters the clock input so a bouncing clock contact yields a single pulse.
// - An internal oscillator with programmable period can replace the clock input as shift source.
// - A setting chooses between pulse mode and latch mode for the output.
// - In pulse mode each data entry reaching the output gives one output pulse of programmable length.
// - In latch mode the output turns on when a data entry has shifted the preset number of places and stays on.
// - In latch mode the output releases at the next shift pulse whose position holds no entry.
`timescale 1ns/1ns

module ctsr_fifo
#(
    parameter int W = 1,
    parameter int D = 8
)
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wp_ff;
    logic [AW:0] rp_ff;
    logic full;
    logic empty;

    assign full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    assign empty = (wp_ff == rp_ff);
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data = mem[rp_ff[AW-1:0]];

    always_ff @(posedge i_clk)
    begin
        if (i_valid && !full)
        begin
            mem[wp_ff[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
        end
        else
        begin
            if (i_valid && !full)
            begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (i_ready && !empty)
            begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end
endmodule

module ctsr_top
    import ctsr_pkg::*;
#(
    parameter int DEPTH = SR_DEPTH
)
(
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_DATA,
    input wire logic I_SHIFT_CLK,
    output logic O_OUT,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    ctsr_ctrl_t ctrl_ff;
    logic [LEN_W-1:0] shift_len_ff;
    logic [31:0] pulse_len_ff;
    logic [31:0] osc_period_ff;
    logic [31:0] shift_cnt_ff;

    // Input synchronisers and filter.
    logic [1:0] d_sync_ff;
    logic [1:0] c_sync_ff;
    logic filt_ff;
    logic filt_q_ff;
    logic [DEB_CW-1:0] deb_cnt_ff;
    logic clk_edge;

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            d_sync_ff <= '0;
            c_sync_ff <= '0;
        end
        else
        begin
            d_sync_ff <= {d_sync_ff[0], I_DATA};
            c_sync_ff <= {c_sync_ff[0], I_SHIFT_CLK};
        end
    end

    // Slow response demands a stable level for the whole debounce time.
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            filt_ff <= 1'b0;
            filt_q_ff <= 1'b0;
            deb_cnt_ff <= '0;
        end
        else
        begin
            filt_q_ff <= filt_ff;
            if (!ctrl_ff.slow || c_sync_ff[1] == filt_ff)
            begin
                deb_cnt_ff <= '0;
                filt_ff <= c_sync_ff[1];
            end
            else if (deb_cnt_ff == DEB_CW'(DEB_CYC - 1))
            begin
                deb_cnt_ff <= '0;
                filt_ff <= c_sync_ff[1];
            end
            else
            begin
                deb_cnt_ff <= deb_cnt_ff + 1'b1;
            end
        end
    end

    assign clk_edge = filt_ff && !filt_q_ff;

    // Internal oscillator.
    logic [31:0] osc_cnt_ff;
    logic osc_tick;

    assign osc_tick = (osc_cnt_ff >= osc_period_ff - 32'h0000_0001);

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST || !ctrl_ff.osc_sel || osc_tick)
        begin
            osc_cnt_ff <= '0;
        end
        else
        begin
            osc_cnt_ff <= osc_cnt_ff + 32'h0000_0001;
        end
    end

    // One shift request waits here while the output buffer is full; later ones are dropped.
    logic tick;
    logic pend_ff;
    logic shift_go;
    logic fifo_in_ready;

    assign tick = ctrl_ff.enable && (ctrl_ff.osc_sel ? osc_tick : clk_edge);
    assign shift_go = pend_ff && fifo_in_ready;

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            pend_ff <= 1'b0;
        end
        else if (tick)
        begin
            pend_ff <= 1'b1;
        end
        else if (shift_go)
        begin
            pend_ff <= 1'b0;
        end
    end

    // Data capture; the clear on a shift wins over a new assertion, which enters the shift directly.
    logic cap_ff;

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            cap_ff <= 1'b0;
        end
        else if (d_sync_ff[1] && !shift_go)
        begin
            cap_ff <= 1'b1;
        end
        else if (shift_go)
        begin
            cap_ff <= 1'b0;
        end
    end

    // Shift memory and output tap.
    logic [DEPTH-1:0] sr_ff;
    logic [5:0] tap;
    logic tap_bit;

    assign tap = shift_len_ff[5:0] - 6'h01;
    assign tap_bit = sr_ff[tap];

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            sr_ff <= '0;
            shift_cnt_ff <= '0;
        end
        else if (shift_go)
        begin
            sr_ff <= {sr_ff[DEPTH-2:0], cap_ff | d_sync_ff[1]};
            shift_cnt_ff <= shift_cnt_ff + 32'h0000_0001;
        end
    end

    // Output buffer carries the bit leaving the tap on every shift.
    logic fo_valid;
    logic fo_ready;
    logic [FIFO_W-1:0] fo_data;
    ctsr_ostate_t st_ff;

    assign fo_ready = (st_ff != OS_PULSE);

    ctsr_fifo #(.W(FIFO_W), .D(FIFO_D)) u_ctsr_fifo
    (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_valid(shift_go),
        .o_ready(fifo_in_ready),
        .i_data(tap_bit),
        .o_valid(fo_valid),
        .i_ready(fo_ready),
        .o_data(fo_data)
    );

    // Output stage.
    ctsr_ostate_t nxt_st;
    logic [31:0] pulse_cnt_ff;
    logic pop;

    assign pop = fo_valid && fo_ready;

    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            OS_IDLE:
            begin
                if (pop && fo_data[0])
                begin
                    nxt_st = ctrl_ff.latch_mode ? OS_LATCH : OS_PULSE;
                end
            end
            OS_PULSE:
            begin
                if (pulse_cnt_ff <= 32'h0000_0001)
                begin
                    nxt_st = OS_IDLE;
                end
            end
            OS_LATCH:
            begin
                if (!ctrl_ff.latch_mode || (pop && !fo_data[0]))
                begin
                    nxt_st = OS_IDLE;
                end
            end
            default:
            begin
                nxt_st = OS_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            st_ff <= OS_IDLE;
            O_OUT <= 1'b0;
            pulse_cnt_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
            O_OUT <= (nxt_st != OS_IDLE);
            if (st_ff == OS_IDLE)
            begin
                pulse_cnt_ff <= pulse_len_ff;
            end
            else if (st_ff == OS_PULSE)
            begin
                pulse_cnt_ff <= pulse_cnt_ff - 32'h0000_0001;
            end
        end
    end

    // AXI4-Lite write channel.
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] waddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic wr_do;
    logic [31:0] wmask;

    assign wr_do = aw_got_ff && w_got_ff && !S_AXI_BVALID;
    assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
            waddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end
        else
        begin
            S_AXI_AWREADY <= !aw_got_ff && !(S_AXI_AWVALID && S_AXI_AWREADY);
            S_AXI_WREADY <= !w_got_ff && !(S_AXI_WVALID && S_AXI_WREADY);
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_got_ff <= 1'b1;
                waddr_ff <= S_AXI_AWADDR[7:0];
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_got_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
                wstrb_ff <= S_AXI_WSTRB;
            end
            if (wr_do)
            begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                if (waddr_ff == OFS_CTRL || waddr_ff == OFS_SHIFT_LEN
                    || waddr_ff == OFS_PULSE_LEN || waddr_ff == OFS_OSC_PERIOD)
                begin
                    S_AXI_BRESP <= RESP_OKAY;
                end
                else
                begin
                    S_AXI_BRESP <= RESP_SLVERR;
                end
            end
            else if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            ctrl_ff <= '0;
            shift_len_ff <= RST_SHIFT_LEN;
            pulse_len_ff <= RST_PULSE_LEN;
            osc_period_ff <= RST_OSC_PERIOD;
        end
        else if (wr_do)
        begin
            if (waddr_ff == OFS_CTRL)
            begin
                if (wstrb_ff[0])
                begin
                    ctrl_ff <= wdata_ff[CTRL_LATCH_BIT:CTRL_EN_BIT];
                end
            end
            else if (waddr_ff == OFS_SHIFT_LEN)
            begin
                if (wstrb_ff[0])
                begin
                    shift_len_ff <= wdata_ff[LEN_W-1:0];
                end
            end
            else if (waddr_ff == OFS_PULSE_LEN)
            begin
                pulse_len_ff <= (pulse_len_ff & ~wmask) | (wdata_ff & wmask);
            end
            else if (waddr_ff == OFS_OSC_PERIOD)
            begin
                osc_period_ff <= (osc_period_ff & ~wmask) | (wdata_ff & wmask);
            end
        end
    end

    // AXI4-Lite read channel.
    logic [31:0] rd_val;
    logic rd_ok;

    always_comb
    begin
        rd_val = '0;
        rd_ok = 1'b1;
        if (S_AXI_ARADDR[7:0] == OFS_CTRL)
        begin
            rd_val[CTRL_LATCH_BIT:CTRL_EN_BIT] = ctrl_ff;
        end
        else if (S_AXI_ARADDR[7:0] == OFS_SHIFT_LEN)
        begin
            rd_val[LEN_W-1:0] = shift_len_ff;
        end
        else if (S_AXI_ARADDR[7:0] == OFS_PULSE_LEN)
        begin
            rd_val = pulse_len_ff;
        end
        else if (S_AXI_ARADDR[7:0] == OFS_OSC_PERIOD)
        begin
            rd_val = osc_period_ff;
        end
        else if (S_AXI_ARADDR[7:0] == OFS_STATUS)
        begin
            rd_val[ST_OUT_BIT] = O_OUT;
            rd_val[ST_FULL_BIT] = !fifo_in_ready;
            rd_val[ST_EMPTY_BIT] = !fo_valid;
            rd_val[ST_PEND_BIT] = pend_ff;
        end
        else if (S_AXI_ARADDR[7:0] == OFS_SHIFT_CNT)
        begin
            rd_val = shift_cnt_ff;
        end
        else
        begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= RESP_OKAY;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_val;
            S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            S_AXI_RVALID <= 1'b0;
        end
        else if (!S_AXI_RVALID)
        begin
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // Checks.
    a_shift_entry: assert property (@(posedge I_CLK) disable iff (I_SRST)
        shift_go |=> sr_ff[0] == $past(cap_ff | d_sync_ff[1])
        && sr_ff[DEPTH-1:1] == $past(sr_ff[DEPTH-2:0]))
        else $error("shift entry wrong");
    a_tap_push: assert property (@(posedge I_CLK) disable iff (I_SRST)
        shift_go && tap_bit && !fo_valid && st_ff == OS_IDLE ##1 ctrl_ff.latch_mode
        |-> ##[0:1] O_OUT)
        else $error("output did not follow tap");
    a_slow_filter: assert property (@(posedge I_CLK) disable iff (I_SRST)
        ctrl_ff.slow && $past(ctrl_ff.slow) && $changed(filt_ff)
        |-> $past(deb_cnt_ff) == DEB_CW'(DEB_CYC - 1))
        else $error("slow filter passed early");
    a_osc_pend: assert property (@(posedge I_CLK) disable iff (I_SRST)
        ctrl_ff.enable && ctrl_ff.osc_sel && osc_tick |=> pend_ff)
        else $error("oscillator tick lost");
    a_mode_drop: assert property (@(posedge I_CLK) disable iff (I_SRST)
        st_ff == OS_LATCH && !ctrl_ff.latch_mode |=> st_ff == OS_IDLE)
        else $error("latch held in pulse mode");
    a_pulse_len: assert property (@(posedge I_CLK) disable iff (I_SRST)
        st_ff == OS_IDLE && nxt_st == OS_PULSE |=> pulse_cnt_ff == $past(pulse_len_ff) && O_OUT)
        else $error("pulse length wrong");
    a_latch_set: assert property (@(posedge I_CLK) disable iff (I_SRST)
        pop && fo_data[0] && ctrl_ff.latch_mode |=> O_OUT ##1 O_OUT || pop)
        else $error("latch not set");
    a_latch_release: assert property (@(posedge I_CLK) disable iff (I_SRST)
        st_ff == OS_LATCH && pop && !fo_data[0] |=> !O_OUT && st_ff == OS_IDLE)
        else $error("latch not released");
    a_capture_hold: assert property (@(posedge I_CLK) disable iff (I_SRST)
        d_sync_ff[1] && !shift_go |=> cap_ff)
        else $error("data assertion lost");
    a_edge_detect: assert property (@(posedge I_CLK) disable iff (I_SRST)
        !ctrl_ff.slow && !$past(ctrl_ff.slow) && $rose(c_sync_ff[1]) |=> clk_edge)
        else $error("clock edge missed");
    c_pulse: cover property (@(posedge I_CLK) st_ff == OS_PULSE ##1 st_ff == OS_IDLE);
    c_latch: cover property (@(posedge I_CLK) st_ff == OS_LATCH ##1 st_ff == OS_IDLE);
    c_full: cover property (@(posedge I_CLK) pend_ff && !fifo_in_ready);
endmodule

// ### bench/ctsr_sensor_model.sv
`timescale 1ns/1ns

module ctsr_sensor_model
(
    output logic o_data,
    output logic o_shift_clk
);
    int n_shift = 0;

    initial
    begin
        o_data = 1'b0;
        o_shift_clk = 1'b0;
    end

    // One frame: the result shows briefly while the clock is low, then one pulse follows.
    task automatic step(input logic d);
        #10;
        o_data = d;
        #100;
        o_data = 1'b0;
        #100;
        o_shift_clk = 1'b1;
        n_shift++;
        #200;
        o_shift_clk = 1'b0;
        #200;
    endtask

    // A contact that chatters for a while before one long closure.
    task automatic bounce();
        #10;
        repeat (4)
        begin
            o_shift_clk = 1'b1;
            #1000;
            o_shift_clk = 1'b0;
            #1000;
        end
        o_shift_clk = 1'b1;
        #15000;
        o_shift_clk = 1'b0;
        #15000;
    endtask
endmodule

// ### bench/tb_ctsr_top.sv
`timescale 1ns/1ns

module tb_ctsr_top;
    import ctsr_pkg::*;

    typedef struct packed {
        logic [7:0] a;
        logic wr;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [1:0] rr;
    } ctsr_row_t;

    localparam ctsr_row_t ROWS [9] = '{
        '{OFS_CTRL, 1'b0, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
        '{OFS_SHIFT_LEN, 1'b0, 32'h0000_0000, 32'h0000_0008, RESP_OKAY},
        '{OFS_PULSE_LEN, 1'b0, 32'h0000_0000, RST_PULSE_LEN, RESP_OKAY},
        '{OFS_OSC_PERIOD, 1'b0, 32'h0000_0000, RST_OSC_PERIOD, RESP_OKAY},
        '{OFS_STATUS, 1'b0, 32'h0000_0000, 32'h0000_0004, RESP_OKAY},
        '{OFS_SHIFT_CNT, 1'b0, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
        '{8'h20, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, RESP_SLVERR},
        '{OFS_PULSE_LEN, 1'b1, 32'h0000_0004, 32'h0000_0004, RESP_OKAY},
        '{OFS_SHIFT_LEN, 1'b1, 32'h0000_0003, 32'h0000_0003, RESP_OKAY}
    };
    localparam logic [9:0] PAT = 10'h00B;

    logic clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, out, awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
    logic [31:0] rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic data, sclk, prev = 1'b0;
    int errors = 0, checks = 0, rises = 0, wcnt = 0, cyc = 0, r0, c0;

    ctsr_sensor_model u_ctsr_sensor_model (.o_data(data), .o_shift_clk(sclk));

    ctsr_top u_ctsr_top (
        .I_CLK(clk), .I_SRST(srst), .I_DATA(data), .I_SHIFT_CLK(sclk), .O_OUT(out),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
    );

    initial
    begin
        forever #25 clk = ~clk;
    end

    // Counts output pulses and the length of the latest one.
    always @(posedge clk)
    begin
        prev <= out;
        if (out === 1'b1 && prev !== 1'b1)
            rises <= rises + 1;
        if (out === 1'b1)
            wcnt <= (prev === 1'b1) ? wcnt + 1 : 1;
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            errors++;
            test_done();
        end
    end

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic test_done();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Handshakes are judged at the falling edge, where registered answers have settled.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clk);
        awaddr <= {24'h00_0000, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
        end while (tb !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge clk);
        araddr <= {24'h00_0000, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge clk);
            ta = arvalid & arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta)
                arvalid <= 1'b0;
        end while (tr !== 1'b1);
        rready <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(out === 1'b0 && bvalid === 1'b0 && rvalid === 1'b0, "reset state");
    endtask

    // Sends ten frames and checks the output after each one settles.
    task automatic run_pat(input logic latch);
        logic e;
        do_reset();
        wr(OFS_SHIFT_LEN, 32'h0000_0003, rs);
        wr(OFS_PULSE_LEN, 32'h0000_0004, rs);
        wr(OFS_CTRL, {28'h000_0000, latch, 3'h1}, rs);
        c0 = u_ctsr_sensor_model.n_shift;
        for (int s = 1; s <= 10; s++)
        begin
            r0 = rises;
            u_ctsr_sensor_model.step(PAT[s-1]);
            repeat (20) @(posedge clk);
            e = (s > 3) ? PAT[s-4] : 1'b0;
            if (latch)
                chk(out === e, "latch output");
            else
                chk((rises - r0) == e && out === 1'b0 && (!e || wcnt == 4), "pulse");
        end
        rd_reg(OFS_SHIFT_CNT, rd, rs);
        chk(rd === u_ctsr_sensor_model.n_shift - c0, "shift count");
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (ROWS[i])
        begin
            if (ROWS[i].wr)
            begin
                wr(ROWS[i].a, ROWS[i].wd, rs);
                chk(rs === ROWS[i].rr, "write response");
            end
            rd_reg(ROWS[i].a, rd, rs);
            chk(rd === ROWS[i].rd && rs === ROWS[i].rr, "register read");
        end
        run_pat(1'b0);
        run_pat(1'b1);
        do_reset();
        wr(OFS_OSC_PERIOD, 32'h0000_000A, rs);
        wr(OFS_CTRL, 32'h0000_0003, rs);
        repeat (200) @(posedge clk);
        wr(OFS_CTRL, 32'h0000_0000, rs);
        rd_reg(OFS_SHIFT_CNT, rd, rs);
        chk(rd >= 32'h0000_0013 && rd <= 32'h0000_0016, "oscillator rate");
        c0 = rd;
        wr(OFS_CTRL, 32'h0000_0005, rs);
        u_ctsr_sensor_model.bounce();
        rd_reg(OFS_SHIFT_CNT, rd, rs);
        chk(rd === c0 + 1, "debounced count");
        wr(OFS_SHIFT_LEN, 32'h0000_0001, rs);
        wr(OFS_PULSE_LEN, 32'h0000_03E8, rs);
        wr(OFS_CTRL, 32'h0000_0001, rs);
        repeat (12) u_ctsr_sensor_model.step(1'b1);
        rd_reg(OFS_STATUS, rd, rs);
        chk(rd[3:0] === 4'hB, "queue full, shift stalled");
        for (int k = 0; k < 200 && rd[3:0] !== 4'h4; k++)
        begin
            repeat (100) @(posedge clk);
            rd_reg(OFS_STATUS, rd, rs);
        end
        chk(rd[3:0] === 4'h4, "queue drained");
        test_done();
    end
endmodule
